/* File: logic/hdld_lock_counter.sv */
// consecutive in-window counter with lock indication
`timescale 1ns/1ps
`default_nettype none
module hdld_lock_counter #(
    parameter int CW = 14
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clear,
    input wire logic tick,
    input wire logic in_window,
    input wire logic [CW-1:0] target,
    output logic locked
);
    logic [CW-1:0] count;
    logic [CW-1:0] goal;
    logic [CW-1:0] next_count;
    // reserved target zero behaves as one
    assign goal = (target == '0) ? CW'(1) : target;
    assign next_count = (count == goal) ? count : count + CW'(1);
    // =====================================================
    // counter, evaluated once per detector cycle
    always_ff @(posedge mclk) begin
        if (reset || clear) begin
            count <= '0;
            locked <= 1'b0;
        end else if (tick) begin
            if (!in_window) begin
                count <= '0;
                locked <= 1'b0;
            end else begin
                count <= next_count;
                locked <= (next_count == goal);
            end
        end
    end
endmodule : hdld_lock_counter
`default_nettype wire

/* File: logic/hdld_map.svh */
// register addresses, field positions, reset values and timing figures
`ifndef HDLD_MAP_SVH
`define HDLD_MAP_SVH
// =====================================================
// serial word layout
`define HDLD_WORD_W 32
`define HDLD_F_ADDR 4:0
`define HDLD_F_RB_SEL 9:5
// =====================================================
// register addresses
`define HDLD_ADDR_TRIP 5'h0E
`define HDLD_ADDR_HOLD 5'h0F
`define HDLD_ADDR_XTAL 5'h10
`define HDLD_ADDR_READBACK 5'h17
`define HDLD_ADDR_DLY_WND 5'h18
`define HDLD_ADDR_DIV_CNT 5'h19
`define HDLD_ADDR_LOOP2 5'h1A
`define HDLD_ADDR_RB_REQ 5'h1F
// =====================================================
// field positions
`define HDLD_F_HIGH_TRIP 19:14
`define HDLD_F_LOW_TRIP 11:6
`define HDLD_F_RAIL_EN 5
`define HDLD_F_MAN_VALUE 31:22
`define HDLD_F_MAN_SEL 20
`define HDLD_F_EXIT_CNT 19:6
`define HDLD_F_FORCE 5
`define HDLD_F_XTAL 31:30
`define HDLD_F_TRACKED 23:14
`define HDLD_F_CAP_FOUR 31:28
`define HDLD_F_CAP_THREE 27:24
`define HDLD_F_RES_FOUR 22:20
`define HDLD_F_RES_THREE 18:16
`define HDLD_F_FB_DLY 14:12
`define HDLD_F_REF_DLY 10:8
`define HDLD_F_L1_WND 7:6
`define HDLD_F_UPD_DIV 31:22
`define HDLD_F_L1_CNT 19:6
`define HDLD_F_L2_WND 31:30
`define HDLD_F_L2_CNT 19:6
`define HDLD_F_MASK 25
// =====================================================
// reset values
`define HDLD_RST_COUNT 14'h0001
`define HDLD_RST_DIV 10'h001
`define HDLD_RST_L2_WND 2'h2
// =====================================================
// tuning scale and lock windows in picoseconds
`define HDLD_TUNE_FULL 16'h03FF
`define HDLD_DLY_STEP_PS 12'h0CD
`define HDLD_WND0_PS 16'h157C
`define HDLD_WND1_PS 16'h2710
`define HDLD_WND2_PS 16'h48A8
`define HDLD_WND3_PS 16'h9C40
`define HDLD_WND_L2_PS 16'h0E74
`endif

/* File: logic/hdld_pkg.sv */
// shared types of the holdover and lock detect block
`default_nettype none
package hdld_pkg;
    // reference loop operating state
    typedef enum logic [0:0] {HDLD_RUN, HDLD_HOLDOVER} hdld_hold_state_t;
    typedef logic [9:0] hdld_tune_t;
    typedef logic [13:0] hdld_count_t;
endpackage : hdld_pkg
`default_nettype wire

/* File: logic/hdld_top.sv */
// holdover tuning value control and digital lock detection
// Summary of operation
// - six-bit low trip code n sets threshold at (n+1)/64 of supply
// - enabled rail detection trip marks reference invalid and raises switch event
// - ten-bit manual tuning code k drives k/1023 of supply in manual mode
// - select zero uses automatic tuning, select one uses manual value
// - holdover exits only after lock holds for exit count detector cycles
// - force bit places device in holdover; clearing removes forcing
// - forced holdover drives manual value if fixed, tracked value if tracked
// - forced holdover switches input only when lock-loss mask is zero
// - tracked tuning value reads back at bits 23 to 14
// - three-bit feedback and reference delay codes in 205 ps steps
// - loop one counter increments below selected window 5.5/10/18.6/40 ns
// - update clock is detector clock divided by ten-bit divisor
// - loop one lock asserts after count consecutive in-window detector cycles
// - loop two counter increments while its error is below its window
// - mask zero: falling loop one lock raises switch event; mask one none
`include "hdld_map.svh"
`timescale 1ns/1ps
`default_nettype none
module hdld_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    input wire logic holdover_track_mode,
    input wire logic pd1_tick,
    input wire logic [15:0] loop1_phase_error,
    input wire logic pd2_tick,
    input wire logic [15:0] loop2_phase_error,
    input wire logic [9:0] auto_tune_value,
    output logic readback_data,
    output hdld_pkg::hdld_tune_t tune_value,
    output logic tune_low_tripped,
    output logic tune_high_tripped,
    output logic clock_switch_event,
    output logic reference_input_invalid,
    output logic loop1_lock_flag,
    output logic loop2_lock_flag,
    output hdld_pkg::hdld_hold_state_t holdover_state,
    output logic tune_update,
    output logic [2:0] loop1_feedback_delay,
    output logic [2:0] loop1_reference_delay,
    output logic [3:0] loop2_filter_cap_four,
    output logic [3:0] loop2_filter_cap_three,
    output logic [2:0] loop2_filter_res_four,
    output logic [2:0] loop2_filter_res_three,
    output logic [1:0] loop2_lock_window,
    output logic [1:0] crystal_drive_level
);
    import hdld_pkg::*;
    // =====================================================
    // helper functions
    // threshold from ground in units of supply/65472
    function automatic logic [15:0] trip_level(input logic [5:0] code);
        trip_level = 16'(({10'h000, code} + 16'h0001) * `HDLD_TUNE_FULL);
    endfunction : trip_level
    // loop one window width in picoseconds
    function automatic logic [15:0] loop1_window_ps(input logic [1:0] code);
        case (code)
            2'h0: loop1_window_ps = `HDLD_WND0_PS;
            2'h1: loop1_window_ps = `HDLD_WND1_PS;
            2'h2: loop1_window_ps = `HDLD_WND2_PS;
            default: loop1_window_ps = `HDLD_WND3_PS;
        endcase
    endfunction : loop1_window_ps
    // =====================================================
    // stored register fields
    logic [5:0] tune_low_trip_level;
    logic [5:0] tune_high_trip_level;
    logic tune_rail_detect_enable;
    logic [9:0] manual_tune_value;
    logic manual_tune_select;
    logic [13:0] holdover_exit_lock_count;
    logic holdover_force;
    logic [1:0] loop1_lock_window;
    logic [9:0] update_divisor;
    logic [13:0] loop1_lock_count;
    logic [13:0] loop2_lock_count;
    logic loop1_lock_loss_switch_mask;
    logic [9:0] tracked_tune_value;
    // =====================================================
    // pin synchronisers; stage one feeds stage two only
    logic [3:0] pin_meta, pin_sync;
    logic ser_clk_prev, ser_latch_prev;
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
            ser_clk_prev <= 1'b0;
            ser_latch_prev <= 1'b0;
        end else begin
            pin_meta <= {holdover_track_mode, ser_latch, ser_data, ser_clk};
            pin_sync <= pin_meta;
            ser_clk_prev <= pin_sync[0];
            ser_latch_prev <= pin_sync[2];
        end
    end
    wire ser_clk_rise = pin_sync[0] && !ser_clk_prev;
    wire ser_latch_rise = pin_sync[2] && !ser_latch_prev;
    wire ser_bit = pin_sync[1];
    wire track_mode = pin_sync[3];
    // =====================================================
    // serial shifter: address in the low five bits, msb first
    logic [`HDLD_WORD_W-1:0] shift_word;
    always_ff @(posedge mclk) begin
        if (reset)
            shift_word <= '0;
        else if (ser_clk_rise)
            shift_word <= {shift_word[`HDLD_WORD_W-2:0], ser_bit};
    end
    wire [4:0] word_addr = shift_word[`HDLD_F_ADDR];
    wire wr_trip = ser_latch_rise && (word_addr == `HDLD_ADDR_TRIP);
    wire wr_hold = ser_latch_rise && (word_addr == `HDLD_ADDR_HOLD);
    wire wr_xtal = ser_latch_rise && (word_addr == `HDLD_ADDR_XTAL);
    wire wr_dly = ser_latch_rise && (word_addr == `HDLD_ADDR_DLY_WND);
    wire wr_div = ser_latch_rise && (word_addr == `HDLD_ADDR_DIV_CNT);
    wire wr_loop2 = ser_latch_rise && (word_addr == `HDLD_ADDR_LOOP2);
    wire rb_request = ser_latch_rise && (word_addr == `HDLD_ADDR_RB_REQ);
    // =====================================================
    // register writes; the readback word has no write strobe
    // readback-only address ignored
    always_ff @(posedge mclk) begin
        if (reset) begin
            tune_low_trip_level <= 6'h00;
            tune_high_trip_level <= 6'h00;
            tune_rail_detect_enable <= 1'b0;
        end else if (wr_trip) begin
            tune_low_trip_level <= shift_word[`HDLD_F_LOW_TRIP];
            tune_high_trip_level <= shift_word[`HDLD_F_HIGH_TRIP];
            tune_rail_detect_enable <= shift_word[`HDLD_F_RAIL_EN];
        end
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            manual_tune_value <= 10'h000;
            manual_tune_select <= 1'b0;
            holdover_exit_lock_count <= `HDLD_RST_COUNT;
            holdover_force <= 1'b0;
        end else if (wr_hold) begin
            manual_tune_value <= shift_word[`HDLD_F_MAN_VALUE];
            manual_tune_select <= shift_word[`HDLD_F_MAN_SEL];
            holdover_exit_lock_count <= shift_word[`HDLD_F_EXIT_CNT];
            holdover_force <= shift_word[`HDLD_F_FORCE];
        end
    end
    always_ff @(posedge mclk) begin
        if (reset)
            crystal_drive_level <= 2'h0;
        else if (wr_xtal)
            crystal_drive_level <= shift_word[`HDLD_F_XTAL];
    end
    // filter codes pass through unchecked; reserved codes are the host's burden
    always_ff @(posedge mclk) begin
        if (reset) begin
            loop2_filter_cap_four <= 4'h0;
            loop2_filter_cap_three <= 4'h0;
            loop2_filter_res_four <= 3'h0;
            loop2_filter_res_three <= 3'h0;
            loop1_feedback_delay <= 3'h0;
            loop1_reference_delay <= 3'h0;
            loop1_lock_window <= 2'h0;
        end else if (wr_dly) begin
            loop2_filter_cap_four <= shift_word[`HDLD_F_CAP_FOUR];
            loop2_filter_cap_three <= shift_word[`HDLD_F_CAP_THREE];
            loop2_filter_res_four <= shift_word[`HDLD_F_RES_FOUR];
            loop2_filter_res_three <= shift_word[`HDLD_F_RES_THREE];
            loop1_feedback_delay <= shift_word[`HDLD_F_FB_DLY];
            loop1_reference_delay <= shift_word[`HDLD_F_REF_DLY];
            loop1_lock_window <= shift_word[`HDLD_F_L1_WND];
        end
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            update_divisor <= `HDLD_RST_DIV;
            loop1_lock_count <= `HDLD_RST_COUNT;
        end else if (wr_div) begin
            update_divisor <= shift_word[`HDLD_F_UPD_DIV];
            loop1_lock_count <= shift_word[`HDLD_F_L1_CNT];
        end
    end
    // mask bit lives here too so one word sets loop two window and count plus the loop one mask
    always_ff @(posedge mclk) begin
        if (reset) begin
            loop2_lock_window <= `HDLD_RST_L2_WND;
            loop2_lock_count <= `HDLD_RST_COUNT;
            loop1_lock_loss_switch_mask <= 1'b0;
        end else if (wr_loop2) begin
            loop2_lock_window <= shift_word[`HDLD_F_L2_WND];
            loop2_lock_count <= shift_word[`HDLD_F_L2_CNT];
            loop1_lock_loss_switch_mask <= shift_word[`HDLD_F_MASK];
        end
    end
    // =====================================================
    // readback word assembly
    logic [31:0] rb_word;
    always_comb begin
        rb_word = 32'h0000_0000;
        case (shift_word[`HDLD_F_RB_SEL])
            `HDLD_ADDR_TRIP: begin
                rb_word[`HDLD_F_LOW_TRIP] = tune_low_trip_level;
                rb_word[`HDLD_F_HIGH_TRIP] = tune_high_trip_level;
                rb_word[`HDLD_F_RAIL_EN] = tune_rail_detect_enable;
            end
            `HDLD_ADDR_HOLD: begin
                rb_word[`HDLD_F_MAN_VALUE] = manual_tune_value;
                rb_word[`HDLD_F_MAN_SEL] = manual_tune_select;
                rb_word[`HDLD_F_EXIT_CNT] = holdover_exit_lock_count;
                rb_word[`HDLD_F_FORCE] = holdover_force;
            end
            `HDLD_ADDR_READBACK: begin
                rb_word[`HDLD_F_TRACKED] = tracked_tune_value;
            end
            `HDLD_ADDR_DIV_CNT: begin
                rb_word[`HDLD_F_UPD_DIV] = update_divisor;
                rb_word[`HDLD_F_L1_CNT] = loop1_lock_count;
            end
            default: rb_word = 32'h0000_0000;
        endcase
    end
    // readback shifter: loads on request, then one bit per serial clock
    logic [31:0] rb_shift;
    always_ff @(posedge mclk) begin
        if (reset) begin
            rb_shift <= 32'h0000_0000;
            readback_data <= 1'b0;
        end else if (rb_request) begin
            rb_shift <= {rb_word[30:0], 1'b0};
            readback_data <= rb_word[31];
        end else if (ser_clk_rise) begin
            rb_shift <= {rb_shift[30:0], 1'b0};
            readback_data <= rb_shift[31];
        end
    end
    // =====================================================
    // lock detection
    logic loop1_locked, loop2_locked, exit_qualified, enter_hold;
    wire [15:0] loop1_wnd_ps = loop1_window_ps(loop1_lock_window);
    wire loop1_in_window = loop1_phase_error < loop1_wnd_ps;
    // loop two compared against its own window
    wire loop2_in_window = loop2_phase_error < `HDLD_WND_L2_PS;
    // consecutive count, cleared by a miss
    hdld_lock_counter #(.CW(14)) u_loop1_lock (
        .mclk(mclk),
        .reset(reset),
        .clear(1'b0),
        .tick(pd1_tick),
        .in_window(loop1_in_window),
        .target(loop1_lock_count),
        .locked(loop1_locked)
    );
    hdld_lock_counter #(.CW(14)) u_loop2_lock (
        .mclk(mclk),
        .reset(reset),
        .clear(1'b0),
        .tick(pd2_tick),
        .in_window(loop2_in_window),
        .target(loop2_lock_count),
        .locked(loop2_locked)
    );
    // exit qualification restarts on every entry
    hdld_lock_counter #(.CW(14)) u_exit_lock (
        .mclk(mclk),
        .reset(reset),
        .clear(enter_hold),
        .tick(pd1_tick),
        .in_window(loop1_locked),
        .target(holdover_exit_lock_count),
        .locked(exit_qualified)
    );
    // update strobe from the detector cycle
    hdld_update_div #(.DW(10)) u_update_div (
        .mclk(mclk),
        .reset(reset),
        .tick(pd1_tick),
        .divisor(update_divisor),
        .update(tune_update)
    );
    // =====================================================
    // rail trip detection against the applied tuning value
    wire [15:0] tune_scaled = {tune_value, 6'h00};
    wire low_trip = tune_scaled <= trip_level(tune_low_trip_level);
    wire [15:0] high_from_gnd = 16'(`HDLD_TUNE_FULL * 16'h0040) - trip_level(tune_high_trip_level);
    wire high_trip = tune_scaled >= high_from_gnd;
    // trip counts only while detection is enabled
    wire rail_trip = tune_rail_detect_enable && (low_trip || high_trip);
    logic rail_trip_prev;
    wire rail_trip_event = rail_trip && !rail_trip_prev;
    wire next_loop1_flag = loop1_locked && (holdover_state == HDLD_RUN) && !enter_hold;
    // falling lock flag switches unless masked
    wire lock_fall_event = loop1_lock_flag && !next_loop1_flag && !loop1_lock_loss_switch_mask;
    // force enters holdover regardless of lock
    assign enter_hold = (holdover_state == HDLD_RUN) && (holdover_force || rail_trip_event ||
                        (!loop1_locked && loop1_lock_flag && !loop1_lock_loss_switch_mask));
    // =====================================================
    // holdover state machine
    hdld_hold_state_t next_hold;
    always_comb begin
        case (holdover_state)
            HDLD_RUN: next_hold = enter_hold ? HDLD_HOLDOVER : HDLD_RUN;
            // leave only when unforced and qualified
            HDLD_HOLDOVER: next_hold = (!holdover_force && exit_qualified) ? HDLD_RUN : HDLD_HOLDOVER;
            default: next_hold = HDLD_RUN;
        endcase
    end
    // =====================================================
    // tracked value and tuning output selection
    logic [9:0] next_tune;
    always_comb begin
        if (holdover_state == HDLD_HOLDOVER) begin
            // fixed mode uses manual code, tracked mode freezes
            next_tune = track_mode ? tracked_tune_value : manual_tune_value;
        end else if (manual_tune_select) begin
            next_tune = manual_tune_value;
        end else begin
            next_tune = tracked_tune_value;
        end
    end
    // automatic value sampled at each update strobe while running with manual select zero
    always_ff @(posedge mclk) begin
        if (reset)
            tracked_tune_value <= 10'h000;
        else if (tune_update && (holdover_state == HDLD_RUN) && !manual_tune_select)
            tracked_tune_value <= auto_tune_value;
    end
    // =====================================================
    // registered status and event outputs
    always_ff @(posedge mclk) begin
        if (reset) begin
            holdover_state <= HDLD_RUN;
            tune_value <= 10'h000;
            rail_trip_prev <= 1'b0;
            tune_low_tripped <= 1'b0;
            tune_high_tripped <= 1'b0;
            loop1_lock_flag <= 1'b0;
            loop2_lock_flag <= 1'b0;
            clock_switch_event <= 1'b0;
            reference_input_invalid <= 1'b0;
        end else begin
            holdover_state <= next_hold;
            tune_value <= next_tune;
            rail_trip_prev <= rail_trip;
            tune_low_tripped <= low_trip;
            tune_high_tripped <= high_trip;
            loop1_lock_flag <= next_loop1_flag;
            loop2_lock_flag <= loop2_locked;
            clock_switch_event <= rail_trip_event || lock_fall_event;
            // invalid marking stays while the enabled rail trip condition persists
            reference_input_invalid <= rail_trip_event || (reference_input_invalid && rail_trip);
        end
    end
endmodule : hdld_top
`default_nettype wire

/* File: logic/hdld_update_div.sv */
// tuning-value update clock divider
`timescale 1ns/1ps
`default_nettype none
module hdld_update_div #(
    parameter int DW = 10
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic tick,
    input wire logic [DW-1:0] divisor,
    output logic update
);
    logic [DW-1:0] count;
    logic [DW-1:0] last;
    // reserved divisor zero behaves as one
    assign last = (divisor == '0) ? '0 : divisor - DW'(1);
    // =====================================================
    // one update pulse every divisor detector cycles
    always_ff @(posedge mclk) begin
        if (reset) begin
            count <= '0;
            update <= 1'b0;
        end else begin
            update <= tick && (count >= last);
            if (tick) begin
                count <= (count >= last) ? '0 : count + DW'(1);
            end
        end
    end
endmodule : hdld_update_div
`default_nettype wire

/* File: verification/hdld_host_model.sv */
// serial host model that programs and reads the block's registers
`timescale 1ns/1ps
`default_nettype none
module hdld_host_model (
    input wire logic mclk,
    input wire logic readback_data,
    output logic ser_clk,
    output logic ser_data,
    output logic ser_latch
);
    // ==========================================
    // pin levels stand five cycles, one above the sync minimum
    initial {ser_clk, ser_data, ser_latch} = 3'b000;
    task automatic step(input logic [2:0] pins);
        @(posedge mclk);
        {ser_clk, ser_data, ser_latch} <= pins;
        repeat (4) @(posedge mclk);
    endtask : step
    task automatic send(input logic [31:0] w);
        if (w[4:0] == 5'h17)
            return;
        for (int i = 31; i >= 0; i--) begin
            step({1'b0, w[i], 1'b0});
            step({1'b1, w[i], 1'b0});
        end
        // released data shows the inverse, never a stale bit
        step({1'b0, ~w[0], 1'b1});
        step({1'b0, ~w[0], 1'b0});
    endtask : send
    // request a readback, then clock the word out msb first
    task automatic fetch(input logic [4:0] sel, output logic [31:0] v);
        send({22'h00_0000, sel, 5'h1F});
        v[31] = readback_data;
        for (int i = 30; i >= 0; i--) begin
            step(3'b100);
            v[i] = readback_data;
            step(3'b000);
        end
    endtask : fetch
endmodule : hdld_host_model
`default_nettype wire

/* File: verification/hdld_properties.sv */
// port-level assertions for the holdover and lock detect block
`timescale 1ns/1ps
`default_nettype none
module hdld_properties (
    input wire logic mclk,
    input wire logic reset,
    input wire logic pd1_tick,
    input wire logic [15:0] loop1_phase_error,
    input wire logic pd2_tick,
    input wire logic [15:0] loop2_phase_error,
    input wire logic tune_update,
    input wire logic clock_switch_event,
    input wire logic reference_input_invalid,
    input wire logic loop1_lock_flag,
    input wire logic loop2_lock_flag,
    input wire logic [1:0] loop2_lock_window,
    input wire hdld_pkg::hdld_hold_state_t holdover_state
);
    import hdld_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // ==========================================
    // event, holdover and lock relations
    property p_pulse; clock_switch_event |=> !clock_switch_event; endproperty
    a_pulse: assert property (p_pulse) else $error("switch event too long");
    property p_invalid; $rose(reference_input_invalid) |-> clock_switch_event; endproperty
    a_invalid: assert property (p_invalid) else $error("invalid without event");
    property p_hold; holdover_state == HDLD_HOLDOVER && $past(holdover_state) == HDLD_HOLDOVER |-> !loop1_lock_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("lock shown in holdover");
    property p_rise; $rose(loop1_lock_flag) |-> holdover_state == HDLD_RUN; endproperty
    a_rise: assert property (p_rise) else $error("lock rose in holdover");
    // a cycle outside every window must clear the flag two clocks on
    property p_clear1; pd1_tick && loop1_phase_error >= 16'h9C40 |-> ##2 !loop1_lock_flag; endproperty
    a_clear1: assert property (p_clear1) else $error("loop one lock not cleared");
    property p_clear2; pd2_tick && loop2_phase_error >= 16'h0E74 |-> ##[1:2] !loop2_lock_flag; endproperty
    a_clear2: assert property (p_clear2) else $error("loop two lock not cleared");
    property p_update; tune_update |-> $past(pd1_tick); endproperty
    a_update: assert property (p_update) else $error("update without tick");
    property p_reset; $fell(reset) |-> holdover_state == HDLD_RUN && loop2_lock_window == 2'h2; endproperty
    a_reset: assert property (p_reset) else $error("bad state after reset");
    c_lock: cover property ($rose(loop1_lock_flag));
    c_hold: cover property (holdover_state == HDLD_HOLDOVER);
    c_trip: cover property ($rose(reference_input_invalid));
endmodule : hdld_properties
bind hdld_top hdld_properties chk (.*);
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench of the holdover and lock detect block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hdld_pkg::*;
    logic mclk, reset, holdover_track_mode, pd1_tick, pd2_tick, ser_clk, ser_data, ser_latch, readback_data;
    logic tune_low_tripped, tune_high_tripped, clock_switch_event, reference_input_invalid, tune_update;
    logic loop1_lock_flag, loop2_lock_flag;
    logic [15:0] loop1_phase_error, loop2_phase_error;
    logic [9:0] auto_tune_value;
    logic [3:0] loop2_filter_cap_four, loop2_filter_cap_three;
    logic [2:0] loop1_feedback_delay, loop1_reference_delay, loop2_filter_res_four, loop2_filter_res_three;
    logic [1:0] loop2_lock_window, crystal_drive_level;
    hdld_tune_t tune_value;
    hdld_hold_state_t holdover_state;
    int err_count, comparisons, cycles, events, e0;
    logic [31:0] word;
    hdld_top dut (.*);
    hdld_host_model host (.*);
    // ==========================================
    // clock, then event tally (pulses last one cycle) and hang guard
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        events <= events + (clock_switch_event === 1'b1);
        if (cycles > 30000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // one detector cycle; the gap lets flag and event settle
    task automatic tick(input logic [15:0] e1, input logic [15:0] e2);
        @(posedge mclk);
        {pd1_tick, pd2_tick, loop1_phase_error, loop2_phase_error} <= {2'b11, e1, e2};
        @(posedge mclk);
        {pd1_tick, pd2_tick} <= 2'b00;
        repeat (5) @(posedge mclk);
    endtask : tick
    task automatic t_regs;
        check(holdover_state, HDLD_RUN);
        host.send({4'hD, 4'h3, 1'b0, 3'h4, 1'b0, 3'h2, 1'b0, 3'h7, 1'b0, 3'h1, 3'h0, 5'h18});
        host.send({2'h2, 10'h000, 14'h0001, 1'b0, 5'h1A});
        check({loop1_feedback_delay, loop1_reference_delay}, 6'h39);
        check({loop2_filter_cap_four, loop2_filter_cap_three, loop2_filter_res_four, loop2_filter_res_three}, 14'h34E2);
        check(loop2_lock_window, 2'h2);
        host.send({2'h3, 25'h000_0000, 5'h10});
        check(crystal_drive_level, 2'h3);
        $display("test regs done");
    endtask : t_regs
    task automatic t_lock;
        host.send({10'h002, 2'h0, 14'h0003, 1'b0, 5'h19});
        tick(16'h1518, 16'h0E10);
        check(tune_value, 10'h000);
        tick(16'h1518, 16'h0E10);
        check({loop1_lock_flag, loop2_lock_flag}, 2'b01);
        check(tune_value, 10'h1C3);
        tick(16'h1518, 16'h0E74);
        check({loop1_lock_flag, loop2_lock_flag}, 2'b10);
        e0 = events;
        tick(16'h157C, 16'h0E10);
        check(loop1_lock_flag, 1'b0);
        check(events, e0 + 1);
        check(holdover_state, HDLD_HOLDOVER);
        for (int i = 0; i < 12 && holdover_state !== HDLD_RUN; i++)
            tick(16'h0064, 16'h0064);
        check(holdover_state, HDLD_RUN);
        $display("test lock done");
    endtask : t_lock
    task automatic t_tune;
        host.fetch(5'h17, word);
        check(word[23:14], 10'h1C3);
        host.send({10'h2A5, 2'h1, 14'h0001, 1'b0, 5'h0F});
        check(tune_value, 10'h2A5);
        host.send({10'h2A5, 2'h1, 14'h0001, 1'b1, 5'h0F});
        check({holdover_state, tune_value}, {HDLD_HOLDOVER, 10'h2A5});
        @(posedge mclk);
        holdover_track_mode <= 1'b1;
        repeat (6) @(posedge mclk);
        check(tune_value, 10'h1C3);
        $display("test tune done");
    endtask : t_tune
    // tracked code 0x1c3 sits between the thresholds of codes 27 and 28
    task automatic t_trip;
        host.send({12'h000, 6'h00, 2'h0, 6'h1B, 1'b1, 5'h0E});
        check(tune_low_tripped, 1'b0);
        e0 = events;
        host.send({12'h000, 6'h00, 2'h0, 6'h1C, 1'b1, 5'h0E});
        check({tune_high_tripped, tune_low_tripped, reference_input_invalid}, 3'b011);
        check(events, e0 + 1);
        $display("test trip done");
    endtask : t_trip
    initial begin
        {reset, holdover_track_mode, pd1_tick, pd2_tick} = 4'b1000;
        {loop1_phase_error, loop2_phase_error, auto_tune_value} = {32'h0000_0000, 10'h1C3};
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        t_regs();
        t_lock();
        t_tune();
        t_trip();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
